// [poe_evt_defs.svh]
// constants for the port voltage and fault event register slice
`ifndef POE_EVT_DEFS_SVH
`define POE_EVT_DEFS_SVH

// register offsets
`define POE_OFF_VOLT_LOW 8'h02
`define POE_OFF_VOLT_HIGH 8'h03
`define POE_OFF_FAULT 8'h04

// voltage low register field: code bits up to this one live in the low byte
`define POE_VL_MSB 7

// voltage high register fields
`define POE_VH_DATA_MSB 1
`define POE_VH_VALID 2
`define POE_VH_UNDERLOAD 3
`define POE_VH_OVERTEMP 4
`define POE_VH_OVERLOAD 5
`define POE_VH_SHORT 6

// fault event register fields
`define POE_FE_LIMIT 0
`define POE_FE_REPEAT_OVL 1
`define POE_FE_DIS_FALL 2
`define POE_FE_INRUSH 3
`define POE_FE_SU_SHORT 4
`define POE_FE_RSVD 5
`define POE_FE_OVERTEMP 6

// voltage code: 10 bits, 58.6 mV per step (kept as tenths of a millivolt)
`define POE_VCODE_BITS 10
`define POE_VLSB_TENTH_MV 586

// refresh period and clock rate
`define POE_REFRESH_US 1000
`define POE_CLK_MHZ 20
`define POE_REFRESH_CYCLES (`POE_REFRESH_US * `POE_CLK_MHZ)

// reset and unmapped read values
`define POE_BYTE_ZERO 8'h00
`define POE_VCODE_ZERO 10'h000

`endif

// [poe_evt_pkg.sv]
// types shared by the port event status register slice
package poe_evt_pkg;

  // event and condition inputs from the port state machines
  typedef struct packed {
    logic underload_evt;
    logic overload_evt;
    logic short_evt;
    logic limit_timeout_evt;
    logic repeated_overload_evt;
    logic inrush_fault_evt;
    logic startup_short_evt;
    logic overtemp_live;
    logic af_mode;
    logic disable_pin;
  } port_evt_t;

  // register access request from the serial host engine
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [voltage_refresh.sv]
// periodic capture of the port voltage code
`timescale 1ns/100ps
`include "poe_evt_defs.svh"

module voltage_refresh
  import poe_evt_pkg::*;
#(
  parameter int REFRESH_CYCLES = `POE_REFRESH_CYCLES,
  parameter int CODE_BITS = `POE_VCODE_BITS
)
(
  input logic clk_sys,
  input logic rst,
  input logic [CODE_BITS-1:0] adc_code,
  output logic [CODE_BITS-1:0] sample,
  output logic sample_new
);

  localparam int CNT_W = $clog2(REFRESH_CYCLES);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CODE_BITS-1:0] sample_reg;
  logic [CODE_BITS-1:0] sample_next;
  logic new_reg;
  logic new_next;

  ////////////////////////////////////////////////////////////////////////////
  // one tick per refresh period takes a fresh code
  always_comb
  begin
    cnt_next = cnt_reg + CNT_W'(1);
    sample_next = sample_reg;
    new_next = 1'b0;
    if (cnt_reg == CNT_W'(REFRESH_CYCLES - 1))
    begin
      cnt_next = '0;
      sample_next = adc_code;
      new_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      sample_reg <= '0;
      new_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sample_reg <= sample_next;
      new_reg <= new_next;
    end
  end

  assign sample = sample_reg;
  assign sample_new = new_reg; // one-cycle pulse
endmodule

// [poe_port_event_status_regs.sv]
// port voltage and latched fault event registers of a single power port
//
// What this block does
// - voltage high bits 1:0 hold code MSBs
// - voltage sample refreshed every millisecond
// - one code step equals 58.6 mV
// - valid bit set on sample, read clears
// - underload, overload, short latch until host clear
// - live overtemp bit, no latch
// - af modes: limit timeout sets overload
// - fault bit 0 latches limit timeout
// - fault bit 1 latches repeated overload
// - fault bit 2 latches disable pin fall
// - fault bit 3 latches inrush fault
// - fault bit 4 latches startup short
// - fault bit 6 latched overtemp, host clears
// - low register holds code bits 7:0
`timescale 1ns/100ps
`include "poe_evt_defs.svh"

module poe_port_event_status_regs
  import poe_evt_pkg::*;
#(
  parameter int REFRESH_CYCLES = `POE_REFRESH_CYCLES
)
(
  input logic clk_sys,
  input logic rst,
  input reg_req_t req,
  output logic [7:0] rdata,
  input logic [`POE_VCODE_BITS-1:0] adc_code,
  input port_evt_t evt
);

  logic [`POE_VCODE_BITS-1:0] sample;
  logic sample_new;

  // latched flags with write-zero clear; set beats a clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic set_evt,
                                     input logic wr_hit, input logic wbit);
    logic keep;
    keep = cur & ~(wr_hit & ~wbit);
    return keep | set_evt;
  endfunction

  // address decode shared by every strobe qualifier
  function automatic logic addr_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample timing

  voltage_refresh #(
    .REFRESH_CYCLES(REFRESH_CYCLES),
    .CODE_BITS(`POE_VCODE_BITS)
  ) u_refresh (
    .clk_sys(clk_sys),
    .rst(rst),
    .adc_code(adc_code),
    .sample(sample),
    .sample_new(sample_new)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  // next-value and registered copies of every flag
  logic [1:0] msb_hold_reg;
  logic [1:0] msb_hold_next;
  logic valid_reg;
  logic valid_next;
  logic underload_flag_reg;
  logic underload_flag_next;
  logic overload_flag_reg;
  logic overload_flag_next;
  logic short_circuit_flag_reg;
  logic short_circuit_flag_next;
  logic [6:0] fault_reg;
  logic [6:0] fault_next;
  logic dis_pin_reg;
  logic dis_pin_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // decoded strobes and read views
  logic hit_low_rd;
  logic hit_high_rd;
  logic hit_high_wr;
  logic hit_fault_wr;
  logic dis_fall;
  logic af_limit;
  logic [7:0] voltage_high_reg;
  logic [7:0] voltage_low_reg;
  logic [7:0] limit_and_startup_fault_events;

  // strobe qualifiers; a read and a write in one cycle both act
  assign hit_low_rd = addr_hit(req.rd, req.addr, `POE_OFF_VOLT_LOW);
  assign hit_high_rd = addr_hit(req.rd, req.addr, `POE_OFF_VOLT_HIGH);
  assign hit_high_wr = addr_hit(req.wr, req.addr, `POE_OFF_VOLT_HIGH);
  assign hit_fault_wr = addr_hit(req.wr, req.addr, `POE_OFF_FAULT);
  assign dis_fall = dis_pin_reg & ~evt.disable_pin;
  assign af_limit = evt.af_mode & evt.limit_timeout_evt;

  ////////////////////////////////////////////////////////////////////////////
  // read views
  always_comb
  begin
    // low byte straight from the current sample
    voltage_low_reg = sample[`POE_VL_MSB:0];
    // bits 7 and unused stay zero
    voltage_high_reg = `POE_BYTE_ZERO;
    // msbs frozen when the low byte was read
    voltage_high_reg[`POE_VH_DATA_MSB:0] = msb_hold_reg;
    voltage_high_reg[`POE_VH_VALID] = valid_reg;
    voltage_high_reg[`POE_VH_UNDERLOAD] = underload_flag_reg;
    voltage_high_reg[`POE_VH_OVERTEMP] = evt.overtemp_live;
    voltage_high_reg[`POE_VH_OVERLOAD] = overload_flag_reg;
    voltage_high_reg[`POE_VH_SHORT] = short_circuit_flag_reg;
    // bits 5 and 7 of the fault register read zero
    limit_and_startup_fault_events = {1'b0, fault_reg};
    limit_and_startup_fault_events[`POE_FE_RSVD] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    msb_hold_next = msb_hold_reg;
    // low read snapshots the msbs so both halves match one sample
    if (hit_low_rd)
      msb_hold_next = sample[`POE_VCODE_BITS-1:`POE_VL_MSB+1];

    // new sample sets, read of high byte clears, set wins
    valid_next = sample_new | (valid_reg & ~hit_high_rd);

    underload_flag_next = flag_next(underload_flag_reg, evt.underload_evt,
                                    hit_high_wr, req.wdata[`POE_VH_UNDERLOAD]);
    // af limit timeout also marks overload
    overload_flag_next = flag_next(overload_flag_reg, evt.overload_evt | af_limit,
                                   hit_high_wr, req.wdata[`POE_VH_OVERLOAD]);
    short_circuit_flag_next = flag_next(short_circuit_flag_reg, evt.short_evt,
                                        hit_high_wr, req.wdata[`POE_VH_SHORT]);

    // write-zero clear on the fault register
    fault_next = fault_reg;
    fault_next[`POE_FE_LIMIT] = flag_next(fault_reg[`POE_FE_LIMIT], evt.limit_timeout_evt,
                                          hit_fault_wr, req.wdata[`POE_FE_LIMIT]);
    fault_next[`POE_FE_REPEAT_OVL] = flag_next(fault_reg[`POE_FE_REPEAT_OVL],
      evt.repeated_overload_evt, hit_fault_wr, req.wdata[`POE_FE_REPEAT_OVL]);
    fault_next[`POE_FE_DIS_FALL] = flag_next(fault_reg[`POE_FE_DIS_FALL], dis_fall,
                                             hit_fault_wr, req.wdata[`POE_FE_DIS_FALL]);
    fault_next[`POE_FE_INRUSH] = flag_next(fault_reg[`POE_FE_INRUSH], evt.inrush_fault_evt,
                                           hit_fault_wr, req.wdata[`POE_FE_INRUSH]);
    fault_next[`POE_FE_SU_SHORT] = flag_next(fault_reg[`POE_FE_SU_SHORT],
      evt.startup_short_evt, hit_fault_wr, req.wdata[`POE_FE_SU_SHORT]);
    // latched overtemp, also set by af limit timeout
    fault_next[`POE_FE_OVERTEMP] = flag_next(fault_reg[`POE_FE_OVERTEMP],
      evt.overtemp_live | af_limit, hit_fault_wr, req.wdata[`POE_FE_OVERTEMP]);
    fault_next[`POE_FE_RSVD] = 1'b0;

    // pin history feeds the fall detector one cycle later
    dis_pin_next = evt.disable_pin;

    // registered read data; unmapped offsets answer zero
    rdata_next = rdata_reg;
    if (req.rd)
    begin
      unique case (req.addr)
        `POE_OFF_VOLT_LOW: rdata_next = voltage_low_reg;
        `POE_OFF_VOLT_HIGH: rdata_next = voltage_high_reg;
        `POE_OFF_FAULT: rdata_next = limit_and_startup_fault_events;
        default: rdata_next = `POE_BYTE_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; the disable pin history resets low so reset never fakes a fall
  // limitation: a pin fall that straddles reset release is not flagged
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      msb_hold_reg <= '0;
      valid_reg <= 1'b0;
      underload_flag_reg <= 1'b0;
      overload_flag_reg <= 1'b0;
      short_circuit_flag_reg <= 1'b0;
      fault_reg <= '0;
      dis_pin_reg <= 1'b0;
      rdata_reg <= `POE_BYTE_ZERO;
    end
    else
    begin
      msb_hold_reg <= msb_hold_next;
      valid_reg <= valid_next;
      underload_flag_reg <= underload_flag_next;
      overload_flag_reg <= overload_flag_next;
      short_circuit_flag_reg <= short_circuit_flag_next;
      fault_reg <= fault_next;
      dis_pin_reg <= dis_pin_next;
      rdata_reg <= rdata_next;
    end
  end

  // code scale is fixed by the converter, one step per 58.6 mV
  assign rdata = rdata_reg;
endmodule

// [poe_evt_checker.sv]
// assertion checker for the port event register slice
`timescale 1ns/100ps
module poe_evt_checker
  import poe_evt_pkg::*;
(
  input logic clk_sys,
  input logic rst,
  input reg_req_t req,
  input logic [7:0] rdata,
  input port_evt_t evt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // an event one cycle ahead of a read shows in the read data
  property p_set(logic e, logic [7:0] a, int b);
    e ##1 (req.rd && req.addr == a) |=> rdata[b];
  endproperty
  // reads of unmapped or reserved places give zeros
  AST_UNMAPPED: assert property (req.rd && !(req.addr inside {8'h02, 8'h03, 8'h04})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  AST_RSVD_FAULT: assert property (req.rd && req.addr == 8'h04
    |=> (rdata & 8'hA0) == 8'h00) else $error("reserved fault bits set");
  // live copy is not latched
  AST_LIVE_OVT: assert property (req.rd && req.addr == 8'h03
    |=> rdata[4] == $past(evt.overtemp_live)) else $error("live overtemp wrong");
  AST_UNDERLOAD: assert property (p_set(evt.underload_evt, 8'h03, 3))
    else $error("underload lost");
  AST_AF_OVL: assert property (p_set(evt.limit_timeout_evt && evt.af_mode, 8'h03, 5))
    else $error("af overload lost");
  AST_LIMIT: assert property (p_set(evt.limit_timeout_evt, 8'h04, 0))
    else $error("limit flag lost");
  AST_OVT_LATCH: assert property (p_set(evt.overtemp_live, 8'h04, 6))
    else $error("overtemp latch lost");
  AST_DIS_FALL: assert property (evt.disable_pin ##1 !evt.disable_pin
    ##1 (req.rd && req.addr == 8'h04) |=> rdata[2]) else $error("pin fall lost");
  // a zero written clears the flag unless the event repeats
  AST_CLEAR: assert property ((req.wr && req.addr == 8'h04 && !req.wdata[0]
    && !evt.limit_timeout_evt) ##1 (req.rd && req.addr == 8'h04) |=> !rdata[0])
    else $error("limit flag not cleared");
  // main scenarios reached
  COV_PAIR: cover property (req.rd && req.addr == 8'h02 ##1 req.rd && req.addr == 8'h03);
  COV_WR: cover property (req.wr && req.addr == 8'h04);
  COV_FALL: cover property (evt.disable_pin ##1 !evt.disable_pin);
endmodule
bind poe_port_event_status_regs poe_evt_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .req(req), .rdata(rdata), .evt(evt));

// [host_model.sv]
// host engine model driving the register strobe port
`timescale 1ns/100ps
module host_model
  import poe_evt_pkg::*;
(
  input logic clk_sys,
  input logic [7:0] rdata,
  output reg_req_t req
);
  initial req = '0;
  ////////////////////////////////////////
  // zero clears, one keeps
  // one access a cycle, entered and left at a falling edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd,
    output logic [7:0] d);
    req = '{a, w, !w, wd};
    @(negedge clk_sys);
    d = rdata;
  endtask
  // drop the strobes so no access repeats
  task automatic idle();
    req = '0;
    @(negedge clk_sys);
  endtask
  // low byte first
  // back to back so both halves belong to one sample
  task automatic vread(output logic [7:0] lo, output logic [7:0] hi);
    xfer(8'h02, 1'b0, 8'h00, lo);
    xfer(8'h03, 1'b0, 8'h00, hi);
    idle();
  endtask
endmodule

// [tb.sv]
// self-checking bench for the port event register slice
`timescale 1ns/100ps
module tb
  import poe_evt_pkg::*;
;
  localparam int REFRESH = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_t req;
  logic [7:0] rdata;
  logic [9:0] adc_code = 10'h2A5;
  logic [9:0] evt_bits = 10'h000;
  port_evt_t evt;
  int err_count = 0;
  int check_count = 0;
  int n;
  logic [7:0] lo, hi, d, m;
  // event input bit, register and flag bit of each latched event
  int ev_idx [8] = '{9, 8, 7, 6, 5, 4, 3, 2};
  logic [7:0] ev_adr [8] = '{8'h03, 8'h03, 8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
  int ev_bit [8] = '{3, 5, 6, 0, 1, 3, 4, 6};
  assign evt = evt_bits;
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  // short refresh count keeps the run brief
  poe_port_event_status_regs #(.REFRESH_CYCLES(REFRESH)) DUT (.clk_sys(clk_sys),
    .rst(rst), .req(req), .rdata(rdata), .adc_code(adc_code), .evt(evt));
  host_model u_host (.clk_sys(clk_sys), .rdata(rdata), .req(req));
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] exp);
    logic [7:0] r;
    u_host.xfer(a, 1'b0, 8'h00, r);
    u_host.idle();
    chk(r & mk, exp);
  endtask
  // one cycle event pulse, other levels kept
  task automatic pulse(input logic [9:0] v);
    evt_bits = evt_bits | v;
    @(negedge clk_sys);
    evt_bits = evt_bits & ~v;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    @(negedge clk_sys);
    do_reset();
    rchk(8'h03, 8'hFF, 8'h00);
    rchk(8'h04, 8'hFF, 8'h00);
    // first sample lands REFRESH cycles after release
    repeat (REFRESH) @(negedge clk_sys);
    u_host.vread(lo, hi);
    chk(lo, 8'hA5);
    chk(hi, 8'h06);
    rchk(8'h03, 8'hFF, 8'h02);
    // poll until the next sample arrives
    adc_code = 10'h13C;
    n = 0;
    do
    begin
      u_host.xfer(8'h03, 1'b0, 8'h00, hi);
      n++;
    end
    while (hi[2] !== 1'b1 && n < 2 * REFRESH);
    u_host.idle();
    if (hi[2] !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
    chk({7'h00, n <= REFRESH}, 8'h01);
    u_host.vread(lo, hi);
    chk(lo, 8'h3C);
    chk(hi, 8'h01);
    // every latched event but the pin fall: set, survives reads and ones, zero clears
    for (int i = 0; i < 8; i++)
    begin
      m = (ev_adr[i] == 8'h03) ? 8'hF8 : 8'hFF;
      pulse(10'h001 << ev_idx[i]);
      rchk(ev_adr[i], m, 8'h01 << ev_bit[i]);
      u_host.xfer(ev_adr[i], 1'b1, 8'hFF, d);
      rchk(ev_adr[i], m, 8'h01 << ev_bit[i]);
      u_host.xfer(ev_adr[i], 1'b1, ~(8'h01 << ev_bit[i]), d);
      rchk(ev_adr[i], m, 8'h00);
    end
    // af mode limit timeout also sets overload and latched overtemp
    evt_bits[1] = 1'b1;
    pulse(10'h040);
    rchk(8'h03, 8'hF8, 8'h20);
    rchk(8'h04, 8'hFF, 8'h41);
    evt_bits[1] = 1'b0;
    u_host.xfer(8'h03, 1'b1, 8'h00, d);
    u_host.xfer(8'h04, 1'b1, 8'h00, d);
    u_host.idle();
    // live overtemp follows the level, latched copy stays
    evt_bits[2] = 1'b1;
    rchk(8'h03, 8'hF8, 8'h10);
    evt_bits[2] = 1'b0;
    rchk(8'h03, 8'hF8, 8'h00);
    rchk(8'h04, 8'hFF, 8'h40);
    // pin rise is ignored, fall latches
    evt_bits[0] = 1'b1;
    @(negedge clk_sys);
    rchk(8'h04, 8'hFF, 8'h40);
    evt_bits[0] = 1'b0;
    @(negedge clk_sys);
    rchk(8'h04, 8'hFF, 8'h44);
    rchk(8'h05, 8'hFF, 8'h00);
    // second reset in mid run drops every flag
    pulse(10'h200);
    do_reset();
    rchk(8'h03, 8'hF8, 8'h00);
    rchk(8'h04, 8'hFF, 8'h00);
    wrap_up();
  end
endmodule
